// [rtl/mfst_top.sv]
// Full-path analogue self-test sequencer with safe-state outputs, error pin and watchdog reactions.
// Assumes a register master on sys_clk, comparator and fault inputs from same-clock logic,
// and an asynchronous error pin.
//
// Notes on behaviour
// R1 - Controller enters run state, checks outputs high
// R2 - Controller selects one shutdown-related comparator bit
// R3 - Writing 07h starts full shutdown-path test
// R4 - Shutdown test completion: wake state, done interrupt
// R5 - Completion sets voltage-fail flag in ierr, or in sfail if a safe-fail comparator was selected
// R6 - Outputs go low, second lags programmed delay
// R7 - Status, monitor flags set, selections cleared
// R8 - Trigger and toggle steps keep outputs low
// R9 - Interrupt test accepted in init, run, wake
// R10 - Interrupt comparator bit, then 0Fh starts
// R11 - Interrupt test sets monitor flag, not done
// R12 - Comparator-only test aborts on severe faults
// R13 - Full-path test blinds real comparator inputs
// R14 - Any abort sets the abort flag
// R15 - Injected faults stay recorded after abort
// R16 - Watchdog fault: interrupt, reset, outputs low, init
// R17 - Controller runs watchdog tests from run state
// R18 - Stopped error toggling flagged and reacted upon
// R19 - Leftover selection bits force failed status
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps

module mfst_top
  import mfst_pkg::*;
#(
  parameter int ERR_TO_CYC = ERR_TO_US * CLK_MHZ,
  parameter int REC_CYC    = REC_US * CLK_MHZ
)(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] cmp_fault_0,
  input  wire logic [7:0] cmp_fault_1,
  input  wire logic [7:0] cmp_fault_2,
  input  wire logic       severe_fault,
  input  wire logic       wdg_fail,
  input  wire logic       err_pin,
  output logic            safe_output_1,
  output logic            safe_output_2,
  output logic            reset_output_n,
  output logic            irq
);

  mfst_state_s     q;
  mfst_state_s     n;
  logic [2:0][7:0] real_f;
  logic [2:0][7:0] vis;
  logic [2:0][7:0] mask;
  logic [2:0][7:0] ms_set;
  logic [2:0][7:0] ms_clr;
  logic [7:0]      ierr_set;
  logic [7:0]      ierr_clr;
  logic [7:0]      sf_set;
  logic [7:0]      sf_clr;
  logic [7:0]      if_set;
  logic            go_safe;
  logic            safe_fs;
  mfst_dev_e       safe_tgt;
  logic            sev_hit;
  logic            fs_hit;
  logic            abort;
  logic            done;
  logic            errfault;
  logic            agree;
  logic            tog_edge;
  logic [CW-1:0]   e_lim;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Clear on software request, but an event in the same cycle wins
  function automatic logic [7:0] w1c(input logic [7:0] old, input logic [7:0] clr, input logic [7:0] set);
    return (old & ~clr) | set;
  endfunction

  // Comparators that belong to the chosen output path
  function automatic logic [7:0] path_mask(input int idx, input logic intp);
    return intp ? INT_MASK[idx] : SS_MASK[idx]; // [R2] [R10]
  endfunction

  assign real_f = {cmp_fault_2, cmp_fault_1, cmp_fault_0};

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb
  begin
    n        = q;
    ms_set   = '0;
    ms_clr   = '0;
    ierr_set = '0;
    ierr_clr = '0;
    sf_set   = '0;
    sf_clr   = '0;
    if_set   = '0;
    go_safe  = 1'b0;
    safe_fs  = 1'b0;
    safe_tgt = DEV_INIT;
    abort    = 1'b0;
    done     = 1'b0;
    errfault = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      mask[i] = path_mask(i, q.ctl0[CTL_INTP]);
    end

    // Error pin: three stages, a change counts once the last two agree
    n.esync  = {q.esync[1:0], err_pin};
    agree    = (q.esync[1] == q.esync[2]);
    if (agree)
    begin
      n.elast = q.esync[2];
    end
    // The artificial toggle source stands in for the pin while enabled
    tog_edge = q.ctl1[C1_TOGEN] | (agree & (q.esync[2] != q.elast)); // [R8]
    e_lim    = q.ctl1[C1_RECEN] ? CW'(ERR_TO_CYC + REC_CYC) : CW'(ERR_TO_CYC);

    // Error monitor, only watched while running
    if (q.dev != DEV_NORMAL || tog_edge)
    begin
      n.ecnt  = '0;
      n.ewarn = 1'b0;
    end
    else
    begin
      n.ecnt = q.ecnt + CW'(1);
      if (q.ctl1[C1_RECEN] && !q.ewarn && q.ecnt == CW'(ERR_TO_CYC - 1))
      begin
        if_set[IF_ERRM] = 1'b1; // [R18]
        n.ewarn         = 1'b1;
      end
      if (q.ecnt == e_lim - CW'(1))
      begin
        errfault = 1'b1; // [R18]
      end
    end

    // Real comparators; blind during a full-path test, selected ones blind during a comparator-only test
    for (int i = 0; i < 3; i++)
    begin
      if (q.tst == TST_RUN)
      begin
        vis[i] = q.ctl0[CTL_PATH] ? 8'h00 : (real_f[i] & ~q.sel[i]); // [R13] [R12]
      end
      else
      begin
        vis[i] = real_f[i];
      end
      ms_set[i] = vis[i] & (SS_MASK[i] | INT_MASK[i]);
    end
    sev_hit = |(vis & SS_MASK);
    fs_hit  = |(vis & FS_MASK);
    if (|(vis & INT_MASK))
    begin
      if_set[IF_MONITOR] = 1'b1;
    end

    // Normal reactions to real faults
    if (sev_hit && q.dev != DEV_STATE_A)
    begin
      go_safe  = 1'b1; // [R12]
      safe_fs  = fs_hit;
      safe_tgt = fs_hit ? DEV_STATE_A : DEV_INIT;
      if (fs_hit)
      begin
        sf_set[SF_VFAIL] = 1'b1;
      end
      else
      begin
        ierr_set[IE_VFAIL] = 1'b1;
      end
    end
    if (errfault)
    begin
      go_safe            = 1'b1;
      safe_tgt           = DEV_INIT;
      ierr_set[IE_ERRM]  = 1'b1; // [R18]
      if_set[IF_ERRM]    = 1'b1;
    end
    if (wdg_fail)
    begin
      go_safe           = 1'b1; // [R16]
      safe_tgt          = DEV_INIT;
      if_set[IF_WDG]    = 1'b1;
      ierr_set[IE_WDG]  = 1'b1;
      n.rcnt            = CW'(RST_CYC);
    end
    else if (q.rcnt != '0)
    begin
      n.rcnt = q.rcnt - CW'(1);
    end
    if (severe_fault)
    begin
      go_safe  = 1'b1; // [R13]
      safe_fs  = 1'b1;
      safe_tgt = DEV_STATE_A;
    end

    // Self-test sequencer
    case (q.tst)
      TST_IDLE:
      begin
        // Start accepted in init, run and wake; refused in the state_a state
        if (reg_wr && reg_addr == A_CTL0 && reg_wdata[CTL_START] && q.dev != DEV_STATE_A) // [R9] [R3] [R10]
        begin
          n.tst  = TST_RUN;
          n.tcnt = CW'(TEST_CYC - 1);
          n.ctl0 = {ST_NONE, reg_wdata[5:1], 1'b0};
          // Injected faults are recorded at once so an abort cannot lose them
          for (int i = 0; i < 3; i++)
          begin
            if (reg_wdata[CTL_PATH])
            begin
              ms_set[i] = ms_set[i] | (q.sel[i] & path_mask(i, reg_wdata[CTL_INTP])); // [R15] [R7]
            end
          end
        end
      end
      TST_RUN:
      begin
        n.tcnt = q.tcnt - CW'(1);
        if (sev_hit || severe_fault || wdg_fail || errfault)
        begin
          abort                      = 1'b1; // [R12] [R13]
          n.tst                      = TST_IDLE;
          sf_set[SF_ABORT]           = 1'b1; // [R14]
          n.ctl0[7:ST_LSB]           = ST_ABORT;
        end
        else if (q.tcnt == '0)
        begin
          done  = 1'b1;
          n.tst = TST_IDLE;
          for (int i = 0; i < 3; i++)
          begin
            n.sel[i] = q.sel[i] & ~mask[i]; // [R7]
          end
          n.ctl0[7:ST_LSB] = (|n.sel) ? ST_FAIL : ST_PASS; // [R19]
          if (!q.ctl0[CTL_PATH])
          begin
            if_set[IF_DONE] = 1'b1;
          end
          else if (q.ctl0[CTL_INTP])
          begin
            if_set[IF_MONITOR] = 1'b1; // [R11]
          end
          else
          begin
            if_set[IF_DONE] = 1'b1; // [R4]
            go_safe         = 1'b1; // [R6]
            safe_tgt        = DEV_WAKE;
            safe_fs         = |(q.sel & mask & FS_MASK);
            if (safe_fs)
            begin
              sf_set[SF_VFAIL] = 1'b1; // [R5]
            end
            else
            begin
              ierr_set[IE_VFAIL] = 1'b1; // [R5]
            end
          end
        end
      end
      default:
      begin
        n.tst = TST_IDLE;
      end
    endcase

    // Register writes
    if (reg_wr)
    begin
      case (reg_addr)
        A_SEL0, A_SEL1, A_SEL2:
        begin
          if (q.tst == TST_IDLE)
          begin
            n.sel[reg_addr[1:0]] = reg_wdata;
          end
        end
        A_CTL1:   n.ctl1   = reg_wdata;
        A_IERR:   ierr_clr = reg_wdata;
        A_SFAIL:  sf_clr   = reg_wdata;
        A_MS1:    ms_clr[0] = reg_wdata;
        A_MS2:    ms_clr[1] = reg_wdata;
        A_MS3:    ms_clr[2] = reg_wdata;
        A_IMASK:  n.imask  = reg_wdata;
        A_SS2DLY: n.ss2dly = reg_wdata;
        A_DEVREQ:
        begin
          if (reg_wdata == REQ_NORMAL && (q.dev == DEV_INIT || q.dev == DEV_WAKE) && !go_safe)
          begin
            n.dev    = DEV_NORMAL;
            n.sout1  = 1'b1;
            n.sout2  = 1'b1;
            n.s2pend = 1'b0;
          end
          else if (reg_wdata == REQ_WAKE && q.dev == DEV_NORMAL && !go_safe)
          begin
            go_safe  = 1'b1;
            safe_tgt = DEV_WAKE;
          end
        end
        default:
        begin
        end
      endcase
    end

    // Safe-state entry; the second output may lag unless safe_fs is set (state_a entry or a safe-fail test end)
    if (go_safe)
    begin
      n.dev   = safe_tgt;
      n.sout1 = 1'b0;
      if (safe_fs || q.ss2dly == 8'h00 || !q.sout2)
      begin
        n.sout2  = 1'b0;
        n.s2pend = 1'b0;
      end
      else if (!q.s2pend)
      begin
        n.s2pend = 1'b1; // [R6]
        n.scnt   = CW'(int'(q.ss2dly) * SS2_UNIT_CYC - 1);
      end
    end
    else if (q.s2pend)
    begin
      n.scnt = q.scnt - CW'(1);
      if (q.scnt == '0)
      begin
        n.sout2  = 1'b0;
        n.s2pend = 1'b0;
      end
    end
    // Overvoltage trigger holds both outputs low whatever else happens
    if (n.ctl1[C1_OVERV])
    begin
      n.sout1  = 1'b0; // [R8]
      n.sout2  = 1'b0;
      n.s2pend = 1'b0;
    end

    // Flag registers, sets win over clears
    n.ierr  = w1c(q.ierr, ierr_clr, ierr_set);
    n.sfail = w1c(q.sfail, sf_clr, sf_set);
    for (int i = 0; i < 3; i++)
    begin
      n.ms[i] = w1c(q.ms[i], ms_clr[i], ms_set[i]);
    end
    n.iflg  = w1c(q.iflg, (reg_rd && reg_addr == A_IFLG) ? 8'hFF : 8'h00, if_set);
    n.irq   = |(n.iflg & n.imask);
    n.rst_n = (n.rcnt == '0); // [R16]

    // Read data, valid only in the cycle after the strobe
    n.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        A_SEL0:   n.rdata = q.sel[0];
        A_SEL1:   n.rdata = q.sel[1];
        A_SEL2:   n.rdata = q.sel[2];
        A_CTL0:   n.rdata = q.ctl0;
        A_CTL1:   n.rdata = q.ctl1;
        A_IERR:   n.rdata = q.ierr;
        A_SFAIL:  n.rdata = q.sfail;
        A_MS1:    n.rdata = q.ms[0];
        A_MS2:    n.rdata = q.ms[1];
        A_MS3:    n.rdata = q.ms[2];
        A_IFLG:   n.rdata = q.iflg;
        A_IMASK:  n.rdata = q.imask;
        A_DEVREQ: n.rdata = {4'h0, q.dev};
        A_SS2DLY: n.rdata = q.ss2dly;
        default:  n.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; clock enable freezes everything

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= ST_RESET;
    end
    else if (ce)
    begin
      q <= n;
    end
  end

  assign reg_rdata      = q.rdata;
  assign safe_output_1  = q.sout1;
  assign safe_output_2  = q.sout2;
  assign reset_output_n = q.rst_n;
  assign irq            = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn || !ce);

  a_start_full_ss: assert property (reg_wr && reg_addr == A_CTL0 && reg_wdata == CMD_FULL_SS && // [R3]
    q.tst == TST_IDLE && q.dev != DEV_STATE_A |=> q.tst == TST_RUN && q.ctl0[CTL_PATH])
    else $error("full-path start not taken");
  a_done_wake: assert property (done && q.ctl0[CTL_PATH] && !q.ctl0[CTL_INTP] |=> // [R4]
    q.dev == DEV_WAKE && q.iflg[IF_DONE] && !safe_output_1)
    else $error("shutdown test end without wake");
  a_vfail_flag: assert property (done && q.ctl0[CTL_PATH] && !q.ctl0[CTL_INTP] |=> // [R5]
    q.ierr[IE_VFAIL] || q.sfail[SF_VFAIL])
    else $error("voltage fail flag missing");
  a_out_low: assert property (q.dev != DEV_NORMAL |-> !safe_output_1) // [R6]
    else $error("safe output high outside run");
  a_overv_low: assert property (q.ctl1[C1_OVERV] |=> !safe_output_1 && !safe_output_2) // [R8]
    else $error("output high under overvoltage trigger");
  a_int_result: assert property (done && q.ctl0[CTL_PATH] && q.ctl0[CTL_INTP] |=> // [R11]
    q.iflg[IF_MONITOR] && q.dev == $past(q.dev))
    else $error("interrupt test result wrong");
  a_abort_flag: assert property (abort |=> q.sfail[SF_ABORT] && q.tst == TST_IDLE && // [R14]
    q.ctl0[7:ST_LSB] == ST_ABORT)
    else $error("abort not recorded");
  a_fail_status: assert property (done |=> (q.ctl0[7:ST_LSB] == ST_FAIL) == (|q.sel)) // [R19]
    else $error("status disagrees with selections");
  a_wdg_react: assert property (wdg_fail |=> !reset_output_n && q.dev == DEV_INIT && // [R16]
    !safe_output_1 ##1 !reset_output_n)
    else $error("watchdog reaction missing");
  a_err_fault: assert property (errfault |=> q.dev == DEV_INIT && q.ierr[IE_ERRM]) // [R18]
    else $error("error monitor reaction missing");
  a_test_len: assert property ($rose(q.tst == TST_RUN) |-> q.tcnt == CW'(TEST_CYC - 1)) // [R7]
    else $error("test length wrong");

  c_done_ss: cover property (done && q.ctl0[CTL_PATH] && !q.ctl0[CTL_INTP]);
  c_done_int: cover property (done && q.ctl0[CTL_INTP]);
  c_abort: cover property (abort);
  c_ss2_lag: cover property (!safe_output_1 && safe_output_2 ##1 !safe_output_2);

endmodule

// [rtl/mfst_pkg.sv]
// Constants, encodings and the state record of the monitor full-path self-test.
// Assumes a single 100 MHz clock domain and an 8-bit register port.
package mfst_pkg;

  // Register offsets
  localparam logic [3:0] A_SEL0   = 4'h0;
  localparam logic [3:0] A_SEL1   = 4'h1;
  localparam logic [3:0] A_SEL2   = 4'h2;
  localparam logic [3:0] A_CTL0   = 4'h3;
  localparam logic [3:0] A_CTL1   = 4'h4;
  localparam logic [3:0] A_IERR   = 4'h5;
  localparam logic [3:0] A_SFAIL  = 4'h6;
  localparam logic [3:0] A_MS1    = 4'h7;
  localparam logic [3:0] A_MS2    = 4'h8;
  localparam logic [3:0] A_MS3    = 4'h9;
  localparam logic [3:0] A_IFLG   = 4'hA;
  localparam logic [3:0] A_IMASK  = 4'hB;
  localparam logic [3:0] A_DEVREQ = 4'hC;
  localparam logic [3:0] A_SS2DLY = 4'hD;

  // Control 0 fields; status sits in bits 7:6
  localparam int CTL_START = 0;
  localparam int CTL_PATH  = 1;
  localparam int CTL_INTP  = 3;
  localparam int ST_LSB    = 6;
  localparam logic [1:0] ST_NONE  = 2'h0;
  localparam logic [1:0] ST_PASS  = 2'h1;
  localparam logic [1:0] ST_FAIL  = 2'h2;
  localparam logic [1:0] ST_ABORT = 2'h3;
  localparam logic [7:0] CMD_FULL_SS  = 8'h07;
  localparam logic [7:0] CMD_FULL_INT = 8'h0F;

  // Control 1 fields
  localparam int C1_OVERV = 0;
  localparam int C1_TOGEN = 1;
  localparam int C1_RECEN = 2;

  // Flag bit positions
  localparam int IF_WDG     = 0;
  localparam int IF_ERRM    = 1;
  localparam int IF_MONITOR = 3;
  localparam int IF_DONE    = 6;
  localparam int IE_WDG     = 0;
  localparam int IE_ERRM    = 1;
  localparam int IE_VFAIL   = 2;
  localparam int SF_VFAIL   = 2;
  localparam int SF_ABORT   = 5;

  // Device state requests
  localparam logic [7:0] REQ_NORMAL = 8'h01;
  localparam logic [7:0] REQ_WAKE   = 8'h02;

  // Comparator classes per select register 0..2
  localparam logic [2:0][7:0] SS_MASK  = {8'hC1, 8'h0E, 8'h2F};
  localparam logic [2:0][7:0] INT_MASK = {8'h30, 8'hF1, 8'hD0};
  localparam logic [2:0][7:0] FS_MASK  = {8'hC0, 8'h00, 8'h00};

  // Timing
  localparam int CLK_MHZ      = 100;
  localparam int TEST_US      = 10;
  localparam int TEST_CYC     = TEST_US * CLK_MHZ;
  localparam int SS2_UNIT_US  = 1;
  localparam int SS2_UNIT_CYC = SS2_UNIT_US * CLK_MHZ;
  localparam int RST_US       = 10;
  localparam int RST_CYC      = RST_US * CLK_MHZ;
  localparam int ERR_TO_US    = 200;
  localparam int REC_US       = 500;
  localparam int CW           = 20;

  typedef enum logic [3:0] {
    DEV_INIT    = 4'h1,
    DEV_NORMAL  = 4'h2,
    DEV_WAKE    = 4'h4,
    DEV_STATE_A = 4'h8
  } mfst_dev_e;

  typedef enum logic [1:0] {
    TST_IDLE = 2'h1,
    TST_RUN  = 2'h2
  } mfst_tst_e;

  typedef struct packed {
    mfst_dev_e        dev;
    mfst_tst_e        tst;
    logic [2:0][7:0]  sel;
    logic [2:0][7:0]  ms;
    logic [7:0]       ctl0;
    logic [7:0]       ctl1;
    logic [7:0]       ierr;
    logic [7:0]       sfail;
    logic [7:0]       iflg;
    logic [7:0]       imask;
    logic [7:0]       ss2dly;
    logic [7:0]       rdata;
    logic [CW-1:0]    tcnt;
    logic [CW-1:0]    scnt;
    logic [CW-1:0]    ecnt;
    logic [CW-1:0]    rcnt;
    logic             sout1;
    logic             sout2;
    logic             s2pend;
    logic             rst_n;
    logic             irq;
    logic [2:0]       esync;
    logic             elast;
    logic             ewarn;
  } mfst_state_s;

  localparam mfst_state_s ST_RESET = '{dev: DEV_INIT, tst: TST_IDLE, rst_n: 1'b1, default: '0};

endpackage

// [dv/mfst_ctrl_model.sv]
// Supervising controller model: register master that sequences the self-tests.
// Assumes the sequencer samples its strobes on the rising edge of sys_clk.
`timescale 1ns/100ps

module mfst_ctrl_model
  import mfst_pkg::*;
(
  input  wire logic       sys_clk,
  output logic      [3:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);

  // Bus idles from time zero
  initial
  begin
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle write strobe beside address and data
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so take them then
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Selection written, then the start command; callers pass one bit, except t_int_path, which passes two
  task automatic launch(input logic [3:0] a, input logic [7:0] s, input logic [7:0] cmd);
    wr(a, s);
    wr(A_CTL0, cmd);
  endtask

endmodule

// [dv/testbench.sv]
// Self-checking bench for the monitor full-path self-test sequencer.
// Assumes the controller model drives the register port; fault inputs come from here.
`timescale 1ns/100ps

module testbench
  import mfst_pkg::*;
;
  localparam int W50 = 50 * CLK_MHZ;

  logic       sys_clk;
  logic       rstn;
  logic       ce;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [7:0] cmp_fault_0;
  logic [7:0] cmp_fault_1;
  logic [7:0] cmp_fault_2;
  logic       severe_fault;
  logic       wdg_fail;
  logic       err_pin;
  logic       err_tog;
  logic [1:0] ecnt;
  logic       safe_output_1;
  logic       safe_output_2;
  logic       reset_output_n;
  logic       irq;
  int         fail_count;
  int         n_tests;

  mfst_top #(.ERR_TO_CYC(50), .REC_CYC(50)) u_mfst_top (
    .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_fault_0(cmp_fault_0),
    .cmp_fault_1(cmp_fault_1), .cmp_fault_2(cmp_fault_2), .severe_fault(severe_fault),
    .wdg_fail(wdg_fail), .err_pin(err_pin), .safe_output_1(safe_output_1),
    .safe_output_2(safe_output_2), .reset_output_n(reset_output_n), .irq(irq));

  mfst_ctrl_model u_mfst_ctrl_model (
    .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  // Alive toggling on the error pin; a stop is the error-monitor fault
  always @(posedge sys_clk)
  begin
    if (err_tog)
      ecnt <= ecnt + 2'h1;
    err_pin <= ecnt[1];
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (fail_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Masked register read compared with an expected value
  task automatic rdchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    u_mfst_ctrl_model.rd(a, d);
    check(d & m, e);
  endtask

  // Bounded wait for output 1, output 2 or the reset line to reach a level
  task automatic wait_pin(input int which, input logic v, input int max, output int n);
    logic s;
    n = 0;
    s = ~v;
    while (s !== v)
    begin
      @(posedge sys_clk);
      #1;
      s = (which == 1) ? safe_output_1 : (which == 2) ? safe_output_2 : reset_output_n;
      n++;
      if (n > max)
      begin
        fail_count++;
        final_report();
      end
    end
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    rstn <= 1'b0;
    cyc(3);
    rstn <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, unmapped read, then run state with both outputs released
  task automatic t_reset_run();
    do_reset();
    check({4'h0, safe_output_1, safe_output_2, reset_output_n, irq}, 8'h02);
    rdchk(A_DEVREQ, 8'hFF, 8'h01);
    rdchk(A_CTL0, 8'hFF, 8'h00);
    rdchk(4'hF, 8'hFF, 8'h00);
    u_mfst_ctrl_model.wr(A_DEVREQ, REQ_NORMAL);
    cyc(3);
    check({6'h0, safe_output_1, safe_output_2}, 8'h03);
  endtask

  // Full shutdown-path test with a 2 us lag on the second output
  task automatic t_ss_path();
    int n;
    u_mfst_ctrl_model.wr(A_IMASK, 8'hFF);
    u_mfst_ctrl_model.wr(A_SS2DLY, 8'h02);
    u_mfst_ctrl_model.launch(A_SEL0, 8'h01, CMD_FULL_SS);
    wait_pin(1, 1'b0, 1100, n);
    check({7'h0, n > 990}, 8'h01);
    wait_pin(2, 1'b0, 300, n);
    check({7'h0, n >= 199 && n <= 201}, 8'h01);
    check({7'h0, irq}, 8'h01);
    rdchk(A_DEVREQ, 8'hFF, 8'h04);
    rdchk(A_IFLG, 8'h40, 8'h40);
    rdchk(A_IERR, 8'h04, 8'h04);
    rdchk(A_SFAIL, 8'h04, 8'h00);
    rdchk(A_CTL0, 8'hC0, {ST_PASS, 6'h00});
    rdchk(A_SEL0, 8'hFF, 8'h00);
    rdchk(A_MS1, 8'h01, 8'h01);
    u_mfst_ctrl_model.wr(A_IERR, 8'h04);
    rdchk(A_IERR, 8'h04, 8'h00);
  endtask

  // Trigger and toggle steps, 50 us apart, with outputs held low
  task automatic t_safe_ctrl();
    logic [7:0] steps [4];
    steps = '{8'h01, 8'h03, 8'h01, 8'h00};
    foreach (steps[i])
    begin
      u_mfst_ctrl_model.wr(A_CTL1, steps[i]);
      cyc(W50);
      check({6'h0, safe_output_1, safe_output_2}, 8'h00);
    end
  endtask

  // Interrupt-path test in wake with one stray selection left over
  task automatic t_int_path();
    logic [7:0] d;
    u_mfst_ctrl_model.rd(A_IFLG, d);
    u_mfst_ctrl_model.launch(A_SEL0, 8'h11, CMD_FULL_INT);
    cyc(1005);
    rdchk(A_IFLG, 8'h48, 8'h08);
    rdchk(A_CTL0, 8'hC0, {ST_FAIL, 6'h00});
    rdchk(A_SEL0, 8'hFF, 8'h01);
    rdchk(A_MS1, 8'h10, 8'h10);
    rdchk(A_DEVREQ, 8'hFF, 8'h04);
  endtask

  // Comparator-only test hit by a real fault on an unselected comparator
  task automatic t_cmp_abort();
    u_mfst_ctrl_model.wr(A_MS1, 8'hFF);
    u_mfst_ctrl_model.launch(A_SEL0, 8'h01, 8'h01);
    cyc(10);
    cmp_fault_0 <= 8'h02;
    cyc(3);
    cmp_fault_0 <= 8'h00;
    cyc(5);
    rdchk(A_CTL0, 8'hC0, {ST_ABORT, 6'h00});
    rdchk(A_SFAIL, 8'h20, 8'h20);
    rdchk(A_DEVREQ, 8'hFF, 8'h01);
    check({7'h0, safe_output_1}, 8'h00);
    u_mfst_ctrl_model.wr(A_SFAIL, 8'hFF);
  endtask

  // Full-path test ignores real comparators, then aborts on a severe fault
  task automatic t_path_abort();
    u_mfst_ctrl_model.wr(A_MS1, 8'hFF);
    u_mfst_ctrl_model.launch(A_SEL0, 8'h01, CMD_FULL_SS);
    cyc(10);
    cmp_fault_0 <= 8'hFF;
    cmp_fault_1 <= 8'hFF;
    cmp_fault_2 <= 8'hFF;
    cyc(20);
    cmp_fault_0 <= 8'h00;
    cmp_fault_1 <= 8'h00;
    cmp_fault_2 <= 8'h00;
    rdchk(A_CTL0, 8'hC0, 8'h00);
    rdchk(A_DEVREQ, 8'hFF, 8'h01);
    severe_fault <= 1'b1;
    @(posedge sys_clk);
    severe_fault <= 1'b0;
    cyc(5);
    rdchk(A_CTL0, 8'hC0, {ST_ABORT, 6'h00});
    rdchk(A_MS1, 8'h01, 8'h01);
    rdchk(A_SFAIL, 8'h20, 8'h20);
    rdchk(A_DEVREQ, 8'hFF, 8'h08);
  endtask

  // Second reset, then a watchdog failure from run state with its interrupt
  task automatic t_watchdog();
    int n;
    t_reset_run();
    u_mfst_ctrl_model.wr(A_IMASK, 8'h01);
    @(posedge sys_clk);
    wdg_fail <= 1'b1;
    @(posedge sys_clk);
    wdg_fail <= 1'b0;
    wait_pin(3, 1'b0, 5, n);
    check({6'h0, safe_output_1, safe_output_2}, 8'h00);
    check({7'h0, irq}, 8'h01);
    // Clock enable low for 100 cycles freezes the countdown, so the pulse stretches by as much
    ce <= 1'b0;
    cyc(100);
    ce <= 1'b1;
    wait_pin(3, 1'b1, 1100, n);
    check({7'h0, n >= 997 && n <= 1002}, 8'h01);
    rdchk(A_DEVREQ, 8'hFF, 8'h01);
    rdchk(A_IFLG, 8'h01, 8'h01);
    cyc(2);
    check({7'h0, irq}, 8'h00);
  endtask

  // Error pin stops toggling in run state
  task automatic t_err_mon();
    int n;
    u_mfst_ctrl_model.wr(A_DEVREQ, REQ_NORMAL);
    cyc(5);
    check({7'h0, safe_output_1}, 8'h01);
    err_tog <= 1'b0;
    wait_pin(1, 1'b0, 200, n);
    check({7'h0, n >= 52 && n <= 57}, 8'h01);
    rdchk(A_IERR, 8'h02, 8'h02);
    rdchk(A_DEVREQ, 8'hFF, 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; every scenario leaves the state the next one starts from
  initial
  begin
    sys_clk      = 1'b0;
    rstn         = 1'b0;
    ce           = 1'b1;
    cmp_fault_0  = 8'h00;
    cmp_fault_1  = 8'h00;
    cmp_fault_2  = 8'h00;
    severe_fault = 1'b0;
    wdg_fail     = 1'b0;
    err_pin      = 1'b0;
    err_tog      = 1'b1;
    ecnt         = 2'h0;
    fail_count   = 0;
    n_tests      = 0;
    t_reset_run();
    t_ss_path();
    t_safe_ctrl();
    t_int_path();
    t_cmp_abort();
    t_path_abort();
    t_watchdog();
    t_err_mon();
    final_report();
  end

endmodule
